// file: rtl/sbff_pkg.sv
/*
 * sbff_pkg: register offsets, field positions, fifo sizes and mode codes
 * of the serial channel buffer/FIFO/flag block.
 * assumes: an AXI4-Lite slave with 32-bit data, one aligned word per register.
 */
package sbff_pkg;
    localparam logic [7:0] SBFF_OFS_CTRL   = 8'h00; // channel_control: errors, clock dir
    localparam logic [7:0] SBFF_OFS_MODE0  = 8'h04; // mode_control_zero: mode field
    localparam logic [7:0] SBFF_OFS_MODE1  = 8'h08; // mode_control_one: duplex field
    localparam logic [7:0] SBFF_OFS_MODE2  = 8'h0C; // mode_control_two: depth, flags
    localparam logic [7:0] SBFF_OFS_FCNF   = 8'h10; // fifo_config
    localparam logic [7:0] SBFF_OFS_TFC    = 8'h14; // tx_fifo_control / rx clear
    localparam logic [7:0] SBFF_OFS_DATA   = 8'h18; // tx write / rx read data
    localparam logic [7:0] SBFF_OFS_STAT   = 8'h1C; // fifo fill levels

    // channel_control fields
    localparam int SBFF_CR_FERR  = 2;
    localparam int SBFF_CR_PERR  = 3;
    localparam int SBFF_CR_OERR  = 4;
    localparam int SBFF_CR_CKDIR = 5;
    // mode_control_two fields
    localparam int SBFF_M2_TX_BUFFER_EMPTY_FLAG = 0;
    localparam int SBFF_M2_RBFLL = 1;
    localparam int SBFF_M2_TX_RUNNING_FLAG = 2;
    localparam int SBFF_M2_STOP_LENGTH_SELECT = 4;
    localparam int SBFF_M2_WBUF  = 5;
    // tx_fifo_control fields
    localparam int SBFF_TFC_TFCLR = 0;
    localparam int SBFF_TFC_RFCLR = 1;
    localparam int SBFF_TFC_TX_BUFFER_CLEAR = 2;

    localparam logic [1:0] SBFF_MODE_IO   = 2'h0;
    localparam logic [1:0] SBFF_DPX_HRX   = 2'h1;
    localparam logic [1:0] SBFF_DPX_HTX   = 2'h2;
    localparam logic [1:0] SBFF_DPX_FULL  = 2'h3;
    localparam logic [2:0] SBFF_FIFO_BYTES = 3'h4;
    localparam logic [2:0] SBFF_FIFO_HALF  = 3'h2;
    localparam logic [1:0] SBFF_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SBFF_RESP_SLVERR = 2'h2;
endpackage

// file: rtl/sbff_core.sv
/*
 * sbff_core: transmit/receive buffers, 4-byte FIFO split by duplex setting,
 * buffer status flags and clear-on-read error flags of one serial channel.
 * assumes: shift engines and sampler outside hand over frames as one-cycle
 * strobes on aclk; the serial clock pin is asynchronous and is synchronised.
 */
// The AXI4-Lite register port and the register offsets were left to the implementer.
// Summary of operation
// R1 - tx and rx buffers can double-buffer, depth chosen by a software bit
// R2 - rx in uart or clock-input io mode always double-buffers
// R3 - other cases single buffer when select is 0, double when 1
// R4 - software confirms tx stopped, then writes 1 to tx buffer clear
// R5 - buffer clear with tx fifo: move one fifo entry, else set empty flag
// R6 - peer must not drive external serial clock while tx is stopped
// R7 - fifo enabled only when depth select and fifo enable both 1
// R8 - software clears fifos after setting duplex and enabling fifo
// R9 - duplex 01: 4 rx, 10: 4 tx, 11: 2 rx plus 2 tx
// R10 - buffer-full and buffer-empty flags meaningful only when double buffered
// R11 - rx full set on frame into buffer, cleared on buffer read
// R12 - tx empty set on move to shifter, cleared on buffer write
// R13 - three error flags in channel control, cleared when it is read
// R14 - error flag meaning depends on mode and clock direction
// R15 - overrun set when next frame completes before buffer is read
// R16 - with rx fifo, no overrun until all usable fifo bytes full
// R17 - clock-output io mode stops driving serial clock when overrun sets
// R18 - software reads channel control before leaving clock-output io mode
// R19 - uart parity flag set when computed and received parity differ
// R20 - clock-input io: clock edge after shifter done, buffer empty, sets underrun
// R21 - clock-output io: underrun flag set when all shifted and clock stopped
// R22 - framing error from first stop bit only; zero in io mode
// R23 - mode field 00 selects io mode, other values uart
// R24 - io clock direction bit 0 drives clock, 1 takes it from pin
// R25 - fifos are first in first out, clear empties at once
// R26 - with rx fifo, rx buffer passes entries on whenever space free
`timescale 1ns/1ps
`default_nettype none
module sbff_core
    import sbff_pkg::*;
(
    input  wire logic        aclk,            // system clock, 25 MHz
    input  wire logic        aresetn,         // synchronous reset, active low
    input  wire logic [7:0]  s_axi_awaddr,    // write address
    input  wire logic        s_axi_awvalid,   // write address valid
    output logic             s_axi_awready,   // write address ready
    input  wire logic [31:0] s_axi_wdata,     // write data
    input  wire logic [3:0]  s_axi_wstrb,     // write strobes
    input  wire logic        s_axi_wvalid,    // write data valid
    output logic             s_axi_wready,    // write data ready
    output logic [1:0]       s_axi_bresp,     // write response
    output logic             s_axi_bvalid,    // write response valid
    input  wire logic        s_axi_bready,    // write response ready
    input  wire logic [7:0]  s_axi_araddr,    // read address
    input  wire logic        s_axi_arvalid,   // read address valid
    output logic             s_axi_arready,   // read address ready
    output logic [31:0]      s_axi_rdata,     // read data
    output logic [1:0]       s_axi_rresp,     // read response
    output logic             s_axi_rvalid,    // read data valid
    input  wire logic        s_axi_rready,    // read data ready
    input  wire logic        rx_frame_done,   // pulse: frame complete in rx shifter
    input  wire logic [7:0]  rx_frame_data,   // received byte
    input  wire logic        rx_parity_bit,   // received parity bit
    input  wire logic        rx_parity_en,    // parity present in frame
    input  wire logic        rx_stop_bit,     // first stop bit sampled at centre
    input  wire logic        tx_shift_take,   // pulse: tx shifter takes a byte
    input  wire logic        tx_shift_idle,   // tx shifter finished output
    input  wire logic        tx_running_flag, // transmit engine active
    input  wire logic        serial_clock_pin,// serial clock pin input (async)
    output logic             tx_buf_valid,    // byte ready for the tx shifter
    output logic [7:0]       tx_buf_data,     // byte offered to the tx shifter
    output logic             sclk_out_en      // drive enable for serial clock
);
    import sbff_pkg::*;

    // registers
    logic [1:0] mode_r, dpx_r;
    logic       wbuf_r, cnfg_r, ckdir_r, stop_length_select_r;
    logic       oerr_r, perr_r, ferr_r;
    logic       rbfll_r, tx_buffer_empty_flag_r;
    logic [7:0] rbuf_r, tbuf_r;
    logic       tbuf_full_r;
    logic [7:0] rf_mem [0:3];
    logic [7:0] tf_mem [0:3];
    logic [1:0] rf_wp_r, rf_rp_r, tf_wp_r, tf_rp_r;
    logic [2:0] rf_cnt_r, tf_cnt_r;
    logic       sc_s1_r, sc_s2_r, sc_s3_r;
    logic       clk_stopped_r;
    logic       aw_hold_r, w_hold_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;

    // mode decode
    wire io_mode    = (mode_r == SBFF_MODE_IO);                        // R23
    wire io_ckin    = io_mode && ckdir_r;                              // R24
    wire io_ckout   = io_mode && !ckdir_r;                             // R24
    wire tx_double  = wbuf_r;                                          // R3
    wire rx_double  = wbuf_r || !io_mode || io_ckin;                   // R2 R3
    wire fifo_on    = wbuf_r && cnfg_r;                                // R7
    wire [2:0] rf_cap = !fifo_on ? 3'h0 :
                        dpx_r == SBFF_DPX_HRX  ? SBFF_FIFO_BYTES :
                        dpx_r == SBFF_DPX_FULL ? SBFF_FIFO_HALF : 3'h0; // R9
    wire [2:0] tf_cap = !fifo_on ? 3'h0 :
                        dpx_r == SBFF_DPX_HTX  ? SBFF_FIFO_BYTES :
                        dpx_r == SBFF_DPX_FULL ? SBFF_FIFO_HALF : 3'h0; // R9
    wire rf_en = (rf_cap != 3'h0);
    wire tf_en = (tf_cap != 3'h0);

    // bus decode: write fires once address and data are both held
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire wr_go   = aw_hold_r && w_hold_r && !s_axi_bvalid;
    wire rd_go   = s_axi_arvalid && s_axi_arready;
    wire wr_data = wr_go && aw_addr_r == SBFF_OFS_DATA;
    wire wr_tfc  = wr_go && aw_addr_r == SBFF_OFS_TFC;
    wire rd_data = rd_go && s_axi_araddr == SBFF_OFS_DATA;
    wire rd_ctrl = rd_go && s_axi_araddr == SBFF_OFS_CTRL;
    wire tb_clr  = wr_tfc && w_data_r[SBFF_TFC_TX_BUFFER_CLEAR];                 // R4
    wire tf_clr  = wr_tfc && w_data_r[SBFF_TFC_TFCLR];                 // R8
    wire rf_clr  = wr_tfc && w_data_r[SBFF_TFC_RFCLR];                 // R8
    wire wr_map  = aw_addr_r <= SBFF_OFS_STAT && aw_addr_r[1:0] == 2'h0;
    wire rd_map  = s_axi_araddr <= SBFF_OFS_STAT && s_axi_araddr[1:0] == 2'h0;

    // receive path: buffer drains into fifo whenever room
    wire rf_free  = rf_en && rf_cnt_r < rf_cap;
    wire rb_to_rf = rbfll_r && rf_free && !rf_clr;                     // R26
    wire rf_pop   = rd_data && rf_en && rf_cnt_r != 3'h0;
    wire rb_pop   = rd_data && !(rf_en && rf_cnt_r != 3'h0);
    wire rb_room  = !rbfll_r || rb_pop || rb_to_rf;
    wire rx_load  = rx_frame_done && rb_room;                          // R11
    wire rx_ovr   = rx_frame_done && !rb_room;                         // R15 R16
    wire par_bad  = rx_parity_en && ((^rx_frame_data) != rx_parity_bit);

    // transmit path: buffer refills from fifo
    wire tf_push   = wr_data && tf_en && (tbuf_full_r || tf_cnt_r != 3'h0)
                     && tf_cnt_r < tf_cap;
    wire tb_write  = wr_data && !tf_push;
    wire tb_take   = tx_shift_take && tbuf_full_r;
    wire tf_to_tb  = tf_en && tf_cnt_r != 3'h0 &&
                     (tb_take || tb_clr || !tbuf_full_r) && !tf_clr;    // R5 R25

    // serial clock pin: s1 feeds only s2, edges seen between s2 and s3
    wire sc_edge   = sc_s2_r ^ sc_s3_r;
    wire under_in  = io_ckin && tx_double && sc_edge && tx_shift_idle
                     && !tbuf_full_r;                                   // R20
    wire ckout_end = io_ckout && tx_double && tx_shift_idle && !tbuf_full_r
                     && !tx_running_flag && !clk_stopped_r;             // R21

    wire [31:0] ctrl_rd = {26'h0, ckdir_r, oerr_r, perr_r, ferr_r, 2'h0};
    wire [31:0] rd_mux  =
        s_axi_araddr == SBFF_OFS_CTRL  ? ctrl_rd :
        s_axi_araddr == SBFF_OFS_MODE0 ? {30'h0, mode_r} :
        s_axi_araddr == SBFF_OFS_MODE1 ? {30'h0, dpx_r} :
        s_axi_araddr == SBFF_OFS_MODE2 ? {26'h0, wbuf_r, stop_length_select_r, 1'b0,
                                          tx_running_flag, rbfll_r, tx_buffer_empty_flag_r} :
        s_axi_araddr == SBFF_OFS_FCNF  ? {31'h0, cnfg_r} :
        s_axi_araddr == SBFF_OFS_DATA  ? {24'h0, (rf_en && rf_cnt_r != 3'h0)
                                          ? rf_mem[rf_rp_r] : rbuf_r} :
        s_axi_araddr == SBFF_OFS_STAT  ? {25'h0, tf_cnt_r, 1'b0, rf_cnt_r} :
        32'h0;

    // axi handshakes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= SBFF_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= SBFF_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_r && !aw_take;
            s_axi_wready  <= !w_hold_r && !w_take;
            if (aw_take) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? SBFF_RESP_OKAY : SBFF_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_map ? rd_mux : 32'h0;
                s_axi_rresp  <= rd_map ? SBFF_RESP_OKAY : SBFF_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // configuration registers; wstrb lane 0 holds every field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r  <= 2'h0;
            dpx_r   <= 2'h0;
            wbuf_r  <= 1'b0;
            cnfg_r  <= 1'b0;
            ckdir_r <= 1'b0;
            stop_length_select_r <= 1'b0;
        end else if (wr_go) begin
            if (aw_addr_r == SBFF_OFS_MODE0) mode_r  <= w_data_r[1:0];
            if (aw_addr_r == SBFF_OFS_MODE1) dpx_r   <= w_data_r[1:0];
            if (aw_addr_r == SBFF_OFS_FCNF)  cnfg_r  <= w_data_r[0];
            if (aw_addr_r == SBFF_OFS_CTRL)  ckdir_r <= w_data_r[SBFF_CR_CKDIR];
            if (aw_addr_r == SBFF_OFS_MODE2) begin
                wbuf_r  <= w_data_r[SBFF_M2_WBUF];                     // R1
                stop_length_select_r <= w_data_r[SBFF_M2_STOP_LENGTH_SELECT];
            end
        end
    end

    // error flags: a setting event wins over the clear-on-read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oerr_r <= 1'b0;
            perr_r <= 1'b0;
            ferr_r <= 1'b0;
        end else begin
            oerr_r <= rx_ovr || (oerr_r && !rd_ctrl);                  // R13 R15
            perr_r <= (rx_load && !io_mode && par_bad) || under_in || ckout_end
                      || (perr_r && !rd_ctrl);                         // R14 R19
            ferr_r <= (rx_load && !io_mode && !rx_stop_bit)
                      || (ferr_r && !rd_ctrl);                         // R22
        end
    end

    // receive buffer and fifo
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rbfll_r  <= 1'b0;
            rbuf_r   <= 8'h00;
            rf_wp_r  <= 2'h0;
            rf_rp_r  <= 2'h0;
            rf_cnt_r <= 3'h0;
        end else begin
            if (rx_load) begin
                rbuf_r  <= rx_frame_data;
                rbfll_r <= rx_double;                                  // R10 R11
            end else if (rb_pop || rb_to_rf) begin
                rbfll_r <= 1'b0;                                       // R11
            end
            if (rf_clr) begin
                rf_wp_r  <= 2'h0;
                rf_rp_r  <= 2'h0;
                rf_cnt_r <= 3'h0;                                      // R25
            end else begin
                if (rb_to_rf) begin
                    rf_mem[rf_wp_r] <= rbuf_r;
                    rf_wp_r <= rf_wp_r + 2'h1;
                end
                if (rf_pop) rf_rp_r <= rf_rp_r + 2'h1;                 // R25
                rf_cnt_r <= rf_cnt_r + {2'h0, rb_to_rf} - {2'h0, rf_pop};
            end
        end
    end

    // transmit buffer and fifo
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tbuf_full_r <= 1'b0;
            tbuf_r      <= 8'h00;
            tx_buffer_empty_flag_r     <= 1'b1;
            tf_wp_r     <= 2'h0;
            tf_rp_r     <= 2'h0;
            tf_cnt_r    <= 3'h0;
        end else begin
            if (tf_to_tb) begin
                tbuf_r      <= tf_mem[tf_rp_r];
                tbuf_full_r <= 1'b1;
                tx_buffer_empty_flag_r     <= 1'b0;
            end else if (tb_write) begin
                tbuf_r      <= w_data_r[7:0];
                tbuf_full_r <= 1'b1;
                tx_buffer_empty_flag_r     <= 1'b0;                                   // R12
            end else if (tb_take || tb_clr) begin
                tbuf_full_r <= 1'b0;
                tx_buffer_empty_flag_r     <= 1'b1;                                   // R5 R12
            end
            if (tf_clr) begin
                tf_wp_r  <= 2'h0;
                tf_rp_r  <= 2'h0;
                tf_cnt_r <= 3'h0;
            end else begin
                if (tf_push) begin
                    tf_mem[tf_wp_r] <= w_data_r[7:0];
                    tf_wp_r <= tf_wp_r + 2'h1;
                end
                if (tf_to_tb) tf_rp_r <= tf_rp_r + 2'h1;
                tf_cnt_r <= tf_cnt_r + {2'h0, tf_push} - {2'h0, tf_to_tb};
            end
        end
    end

    // serial clock pin sync and clock output enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sc_s1_r       <= 1'b0;
            sc_s2_r       <= 1'b0;
            sc_s3_r       <= 1'b0;
            clk_stopped_r <= 1'b0;
            sclk_out_en   <= 1'b0;
            tx_buf_valid  <= 1'b0;
            tx_buf_data   <= 8'h00;
        end else begin
            sc_s1_r <= serial_clock_pin;
            sc_s2_r <= sc_s1_r;
            sc_s3_r <= sc_s2_r;
            // clock output halts on overrun or completed output
            if (!io_ckout || rd_ctrl)
                clk_stopped_r <= 1'b0;
            if (ckout_end || (io_ckout && rx_ovr))
                clk_stopped_r <= 1'b1;                                 // R17 R21
            sclk_out_en  <= io_ckout && !clk_stopped_r && !(rx_ovr || ckout_end);
            tx_buf_valid <= tbuf_full_r && !tb_take;
            tx_buf_data  <= tbuf_r;
        end
    end

    // a frame that finds no room in buffer or fifo must raise overrun next cycle
    ovr_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_ovr |=> oerr_r) else $error("overrun not flagged"); // R15
    clr_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_ctrl && !rx_ovr |=> !oerr_r) else $error("overrun not cleared"); // R13
    io_ferr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        io_mode && $past(io_mode) && !$past(ferr_r) |-> !ferr_r)
        else $error("framing set in io mode"); // R22
    rbfll_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_load && rx_double && !rf_en |=> rbfll_r) else $error("full not set"); // R11
    tx_buffer_empty_flag_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tb_write |=> !tx_buffer_empty_flag_r) else $error("empty not cleared"); // R12
    fifo_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(wbuf_r && cnfg_r) |-> rf_cap == 3'h0 && tf_cap == 3'h0)
        else $error("fifo on without enable"); // R7
    rf_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rf_cnt_r <= SBFF_FIFO_BYTES) else $error("rx fifo overfilled"); // R9
    sclk_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        io_ckout && rx_ovr |=> !sclk_out_en) else $error("clock kept on"); // R17
    tx_buffer_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tb_clr && !tf_en && !tb_write |=> tx_buffer_empty_flag_r) else $error("clear missed"); // R5
endmodule
`default_nettype wire

// file: dv/sbff_peer.sv
/* sbff_peer: far-side model giving frames to the rx path, taking tx bytes
   and making the link clock. assumes: tasks are called right after an aclk edge. */
`timescale 1ns/1ps
`default_nettype none
module sbff_peer (
    input  wire logic aclk,             // system clock
    output logic      rx_frame_done,    // frame complete pulse
    output logic [7:0] rx_frame_data,   // received byte
    output logic      rx_parity_bit,    // received parity bit
    output logic      rx_parity_en,     // parity present
    output logic      rx_stop_bit,      // first stop bit
    output logic      tx_shift_take,    // shifter takes byte
    output logic      tx_shift_idle,    // shifter done
    output logic      tx_running_flag,  // transmit engine active
    output logic      serial_clock_pin  // link clock, still between bursts
);
    initial begin
        {rx_frame_done, rx_frame_data, rx_parity_bit, rx_parity_en, rx_stop_bit} = '0;
        {tx_shift_take, tx_running_flag, serial_clock_pin} = '0;
        tx_shift_idle = 1'b1;
    end
    task automatic frame(input logic [7:0] d, input logic pe, input logic p, input logic s);
        @(posedge aclk);
        {rx_frame_done, rx_frame_data, rx_parity_en, rx_parity_bit, rx_stop_bit} <= {1'b1, d, pe, p, s};
        @(posedge aclk);
        // after the strobe the data, parity and stop lines no longer show the frame; parity enable keeps its value
        {rx_frame_done, rx_frame_data, rx_parity_bit, rx_stop_bit} <= {1'b0, ~d, ~p, ~s};
    endtask
    task automatic take();
        @(posedge aclk);
        tx_shift_take <= 1'b1;
        @(posedge aclk);
        tx_shift_take <= 1'b0;
    endtask
    task automatic sclk(input int n);
        @(posedge aclk);
        tx_running_flag <= 1'b1;
        #7;
        repeat (n) begin
            #160 serial_clock_pin = 1'b1;
            #160 serial_clock_pin = 1'b0;
        end
        @(posedge aclk);
        tx_running_flag <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: dv/test_serial_buffer_fifo_flags.sv
/* test_serial_buffer_fifo_flags: register-level test of buffers, fifo and flags.
   assumes: sbff_pkg, sbff_core and sbff_peer are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module test_serial_buffer_fifo_flags;
    import sbff_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, rx_frame_done, rx_parity_bit, rx_parity_en, rx_stop_bit;
    logic        tx_shift_take, tx_shift_idle, tx_running_flag, serial_clock_pin;
    logic        tx_buf_valid, sclk_out_en;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_frame_data, tx_buf_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, p0, p1;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          n_fail, check_count, k;
    sbff_core i_sbff_core (.*);
    sbff_peer i_sbff_peer (.*);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 64) begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        if (n == 64) begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        cmp($sformatf("reg %h", a), e, d & m);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h1;
        {n_fail, check_count} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rc(SBFF_OFS_MODE2, 32'h7, 32'h1);
        rd(8'h20, p0, rs);
        cmp("unmapped resp", {30'h0, SBFF_RESP_SLVERR}, {30'h0, rs});
        wr(8'h21, 32'h0);
        cmp("unmapped bresp", {30'h0, SBFF_RESP_SLVERR}, {30'h0, s_axi_bresp});
        wr(SBFF_OFS_MODE0, 32'h1);
        i_sbff_peer.frame(8'hA5, 1'b0, 1'b0, 1'b1);
        rc(SBFF_OFS_MODE2, 32'h2, 32'h2);
        i_sbff_peer.frame(8'h5A, 1'b0, 1'b0, 1'b1);
        rc(SBFF_OFS_CTRL, 32'h1C, 32'h10);
        rc(SBFF_OFS_CTRL, 32'h1C, 32'h0);
        rc(SBFF_OFS_DATA, 32'hFF, 32'hA5);
        rc(SBFF_OFS_MODE2, 32'h2, 32'h0);
        // parity sense is the design's choice, so one of the two must flag
        i_sbff_peer.frame(8'h01, 1'b1, 1'b0, 1'b0);
        rd(SBFF_OFS_CTRL, p0, rs);
        rc(SBFF_OFS_DATA, 32'hFF, 32'h01);
        i_sbff_peer.frame(8'h01, 1'b1, 1'b1, 1'b1);
        rd(SBFF_OFS_CTRL, p1, rs);
        rc(SBFF_OFS_DATA, 32'hFF, 32'h01);
        cmp("framing", 32'h2, {30'h0, p0[2], p1[2]});
        cmp("parity", 32'h1, {31'h0, p0[3] ^ p1[3]});
        wr(SBFF_OFS_MODE2, 32'h20);
        wr(SBFF_OFS_DATA, 32'h3C);
        // the tx outputs follow the buffer one edge after the write lands
        @(negedge aclk);
        cmp("tx buf", 32'h13C, {23'h0, tx_buf_valid, tx_buf_data});
        rc(SBFF_OFS_MODE2, 32'h21, 32'h20);
        i_sbff_peer.take();
        rc(SBFF_OFS_MODE2, 32'h1, 32'h1);
        wr(SBFF_OFS_MODE1, SBFF_DPX_HRX);
        wr(SBFF_OFS_FCNF, 32'h1);
        wr(SBFF_OFS_TFC, 32'h2);
        for (k = 0; k < 5; k++) i_sbff_peer.frame(8'h10 + k[7:0], 1'b0, 1'b0, 1'b1);
        rc(SBFF_OFS_STAT, 32'h77, 32'h4);
        rc(SBFF_OFS_CTRL, 32'h10, 32'h0);
        i_sbff_peer.frame(8'hEE, 1'b0, 1'b0, 1'b1);
        rc(SBFF_OFS_CTRL, 32'h10, 32'h10);
        for (k = 0; k < 5; k++) rc(SBFF_OFS_DATA, 32'hFF, 32'h10 + k);
        wr(SBFF_OFS_MODE1, SBFF_DPX_HTX);
        wr(SBFF_OFS_TFC, 32'h1);
        for (k = 1; k < 4; k++) wr(SBFF_OFS_DATA, 32'h11 * k);
        rc(SBFF_OFS_STAT, 32'h77, 32'h20);
        rc(SBFF_OFS_MODE2, 32'h4, 32'h0);
        for (k = 2; k < 4; k++) begin
            wr(SBFF_OFS_TFC, 32'h4);
            @(negedge aclk);
            cmp("tx buf", 32'h11 * k, {24'h0, tx_buf_data});
        end
        wr(SBFF_OFS_TFC, 32'h4);
        rc(SBFF_OFS_MODE2, 32'h1, 32'h1);
        wr(SBFF_OFS_FCNF, 32'h0);
        wr(SBFF_OFS_MODE0, SBFF_MODE_IO);
        wr(SBFF_OFS_CTRL, 32'h20);
        i_sbff_peer.sclk(4);
        rc(SBFF_OFS_CTRL, 32'h0C, 32'h08);
        // a held tx byte keeps the clock-output side from stopping at once
        wr(SBFF_OFS_DATA, 32'h5A);
        wr(SBFF_OFS_CTRL, 32'h0);
        @(negedge aclk);
        cmp("clk drive", 32'h1, {31'h0, sclk_out_en});
        i_sbff_peer.frame(8'h21, 1'b0, 1'b0, 1'b0);
        i_sbff_peer.frame(8'h22, 1'b0, 1'b0, 1'b0);
        for (k = 0; k < 8 && sclk_out_en !== 1'b0; k++) @(posedge aclk);
        cmp("clk drive", 32'h0, {31'h0, sclk_out_en});
        rc(SBFF_OFS_CTRL, 32'h4, 32'h0);
        wr(SBFF_OFS_TFC, 32'h4);
        rc(SBFF_OFS_CTRL, 32'h8, 32'h8);
        close_out();
    end
endmodule
`default_nettype wire
